// ---- design/quad_dac_regs.svh ----
`ifndef QUAD_DAC_REGS_SVH
`define QUAD_DAC_REGS_SVH

// Register addresses on the serial link
`define QD_ADDR_NOP        4'h0
`define QD_ADDR_ID         4'h1
`define QD_ADDR_SYNC       4'h2
`define QD_ADDR_CONFIG     4'h3
`define QD_ADDR_GAIN       4'h4
`define QD_ADDR_TRIGGER    4'h5
`define QD_ADDR_BCAST      4'h6
`define QD_ADDR_STATUS     4'h7
// Channel code registers sit at 0x8..0xb: upper address bits select the page
`define QD_CODE_PAGE       2'h2

// Field positions
`define QD_SYNC_EN_LSB     0
`define QD_BCAST_EN_LSB    8
`define QD_CFG_REF_OFF_BIT 8
`define QD_CFG_ALARM_ENABLE_BIT_BIT  12
`define QD_CFG_ALARM_SELECT_BIT_BIT 13
`define QD_GAIN_CH_LSB     0
`define QD_GAIN_DIV_BIT    8
`define QD_TRIG_LOAD_BIT   4
`define QD_STATUS_ALM_BIT  0
`define QD_SOFT_RESET_CODE 16'h1010

// Frame layout
`define QD_FRAME_BITS      24
`define QD_RW_BIT          23
`define QD_RSV_MSB         22
`define QD_RSV_LSB         20
`define QD_ADDR_MSB        19
`define QD_ADDR_LSB        16
`define QD_DATA_MSB        15

// Reset values
`define QD_CODE_ZERO       16'h0000
`define QD_CODE_MID        16'h8000
`define QD_SYNC_EN_RST     4'h0
`define QD_BCAST_EN_RST    4'hf

// Timing
`define QD_CLK_FREQ_MHZ    125
`define QD_POR_WAIT_US     250
`define QD_POR_WAIT_CYC    (`QD_POR_WAIT_US * `QD_CLK_FREQ_MHZ)
`define QD_SETTLE_CYC      2'h3

`endif

// ---- design/quad_dac_pkg.sv ----
package quad_dac_pkg;
	typedef enum logic [1:0] {ST_SETTLE, ST_LOAD, ST_RUN} init_state_e;
	typedef logic [15:0] code_t;
	typedef logic [23:0] frame_t;
endpackage

// ---- design/spi_frame_rx.sv ----
`include "quad_dac_regs.svh"

module spi_frame_rx (
	// Clock and reset
	input  wire logic              i_core_clk,
	input  wire logic              i_reset_n,
	// Serial pins, asynchronous to the core clock
	input  wire logic              i_sclk,
	input  wire logic              i_cs_n,
	input  wire logic              i_sdi,
	// Word shifted out during the next frame
	input  wire quad_dac_pkg::frame_t i_resp_word,
	// Received frame
	output logic                   o_frame_vld,
	output quad_dac_pkg::frame_t   o_frame_word,
	output logic                   o_sdo_bit,
	output logic                   o_cs_active
);
	localparam logic [2:0] PIN_IDLE = 3'h2;

	logic [2:0]           s1_ff;
	logic [2:0]           s2_ff;
	logic [2:0]           s3_ff;
	logic [2:0]           flt_ff;
	logic [2:0]           prev_ff;
	quad_dac_pkg::frame_t rx_ff;
	quad_dac_pkg::frame_t tx_ff;
	logic [4:0]           cnt_ff;
	logic                 sclk_fall;
	logic                 sclk_rise;
	logic                 cs_fall;
	logic                 cs_rise;
	logic [2:0]           pin_raw;

	// Gather the pins in one vector so the synchroniser loop can index them
	assign pin_raw = {i_sclk, i_cs_n, i_sdi};

	// Three-stage synchroniser; a level counts once stages two and three agree
	genvar g;
	generate
		for (g = 0; g < 3; g++)
		begin : g_sync
			always_ff @(posedge i_core_clk or negedge i_reset_n)
			begin
				if (!i_reset_n)
				begin
					s1_ff[g]  <= PIN_IDLE[g];
					s2_ff[g]  <= PIN_IDLE[g];
					s3_ff[g]  <= PIN_IDLE[g];
					flt_ff[g] <= PIN_IDLE[g];
				end
				else
				begin
					s1_ff[g] <= pin_raw[g];
					s2_ff[g] <= s1_ff[g];
					s3_ff[g] <= s2_ff[g];
					if (s2_ff[g] == s3_ff[g])
						flt_ff[g] <= s3_ff[g];
				end
			end
		end
	endgenerate

	// Edge history of the filtered pins
	always_ff @(posedge i_core_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			prev_ff <= PIN_IDLE;
		else
			prev_ff <= flt_ff;
	end

	assign sclk_fall = prev_ff[2] & ~flt_ff[2];
	assign sclk_rise = ~prev_ff[2] & flt_ff[2];
	assign cs_fall   = prev_ff[1] & ~flt_ff[1];
	assign cs_rise   = ~prev_ff[1] & flt_ff[1];

	// Receive on falling SCLK; only the last 24 bits survive a long frame
	always_ff @(posedge i_core_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			rx_ff  <= '0;
			cnt_ff <= 5'h0;
		end
		else if (cs_fall)
			cnt_ff <= 5'h0;
		else if (!flt_ff[1] && sclk_fall)
		begin
			rx_ff <= {rx_ff[22:0], flt_ff[0]};
			if (cnt_ff != 5'(`QD_FRAME_BITS))
				cnt_ff <= cnt_ff + 5'h1;
		end
	end

	// Short frames are dropped at the chip-select rising edge
	always_ff @(posedge i_core_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			o_frame_vld  <= 1'b0;
			o_frame_word <= '0;
		end
		else
		begin
			o_frame_vld <= cs_rise && (cnt_ff == 5'(`QD_FRAME_BITS));
			if (cs_rise)
				o_frame_word <= rx_ff;
		end
	end

	// Response is loaded at frame start and moves on rising SCLK
	always_ff @(posedge i_core_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			tx_ff <= '0;
		else if (cs_fall)
			tx_ff <= i_resp_word;
		else if (!flt_ff[1] && sclk_rise)
			tx_ff <= {tx_ff[22:0], 1'b0};
	end

	assign o_sdo_bit   = tx_ff[23];
	assign o_cs_active = ~flt_ff[1];
endmodule

// ---- design/quad_dac_update_control.sv ----
`include "quad_dac_regs.svh"

// What this block does
// - After any reset every code register loads zero or midscale per strap.
// - Codes are unsigned straight binary, full 16-bit range kept.
// - Divide factor starts from strap, then follows divider bit; 1 means halve.
// - Per-channel gain starts from gain strap, then follows its gain bit.
// - Code writes land in the buffer, then move to active now or on load.
// - Reading a code register returns the buffer value, not the active one.
// - Channel with sync bit clear updates active at the frame end.
// - Sync channel moves buffer to active only on load bit or load pin.
// - Each channel has a broadcast participation bit in the sync register.
// - Broadcast write updates all participating channels whatever their sync mode.
// - Internal reference on after reset, off when software sets the config ref-off bit.
// - Bad divider setting raises alarm, kills reference buffer, zeroes outputs, keeps codes.
// - Alarm condition readable as a status register flag.
// - Alarm enable and select both set turn serial output into alarm.
// - Power-on reset returns every register to its default.
// - Outputs keep power-up level until a command addresses the channel.
// - Writing 0x1010 to the soft-reset field starts a full reset.
// - Frames are 24 bits: rw, three zero bits, address, sixteen data.
module quad_dac_update_control #(
	parameter int          POR_WAIT_CYC = `QD_POR_WAIT_CYC,
	parameter logic [15:0] ID_CODE      = 16'h0a5c // Arbitrary identity value
) (
	// Clock and reset
	input  wire logic                i_core_clk,
	input  wire logic                i_reset_n,
	// Serial link
	input  wire logic                i_sclk,
	input  wire logic                i_cs_n,
	input  wire logic                i_sdi,
	output logic                     o_shared_serial_output_pin,
	output logic                     o_shared_serial_output_pin_oe,
	// Strap and trigger pins
	input  wire logic                i_reset_level_select_pin,
	input  wire logic                i_divider_select_pin,
	input  wire logic                i_gain_pin,
	input  wire logic                i_load_trigger_n,
	// Headroom comparator from the reference path
	input  wire logic                i_ref_headroom_low,
	// Converter controls
	output quad_dac_pkg::code_t      o_active_code [4],
	output logic [3:0]               o_gain_x2,
	output logic                     o_ref_div2,
	output logic                     o_int_ref_en,
	output logic                     o_ref_buf_en,
	output logic                     o_outputs_zero,
	output logic                     o_reference_alarm_flag,
	output logic                     o_link_ready
);
	// Pin order: headroom, load_n, gain, divider, reset level
	localparam logic [4:0] PIN_IDLE = 5'h08;

	logic [4:0]                s1_ff;
	logic [4:0]                s2_ff;
	logic [4:0]                s3_ff;
	logic [4:0]                pin_ff;
	logic [4:0]                pin_raw;
	logic                      load_prev_ff;
	quad_dac_pkg::init_state_e state_ff;
	logic [1:0]                settle_ff;
	logic [15:0]               por_cnt_ff;
	quad_dac_pkg::code_t       buf_ff [4];
	logic [3:0]                sync_en_ff;
	logic [3:0]                bcast_en_ff;
	logic                      ref_off_ff;
	logic                      alarm_enable_bit_ff;
	logic                      alarm_select_bit_ff;
	quad_dac_pkg::frame_t      resp_ff;
	quad_dac_pkg::frame_t      frm_word;
	logic                      frm_vld;
	logic                      sdo_bit;
	logic                      cs_active;
	logic                      init_load;
	logic                      acc;
	logic                      wr;
	logic [3:0]                f_addr;
	quad_dac_pkg::code_t       f_data;
	logic                      soft_rst;
	logic                      load_trig;
	logic                      wr_bcast;
	logic                      alarm_cond;

	// Exact match against one register address
	function automatic logic hit(input logic [3:0] addr, input logic [3:0] target);
		hit = (addr == target);
	endfunction

	spi_frame_rx u_rx (
		.i_core_clk   (i_core_clk),
		.i_reset_n    (i_reset_n),
		.i_sclk       (i_sclk),
		.i_cs_n       (i_cs_n),
		.i_sdi        (i_sdi),
		.i_resp_word  (resp_ff),
		.o_frame_vld  (frm_vld),
		.o_frame_word (frm_word),
		.o_sdo_bit    (sdo_bit),
		.o_cs_active  (cs_active)
	);

	// Raw pins in one vector, in the order of PIN_IDLE
	assign pin_raw = {i_ref_headroom_low, i_load_trigger_n, i_gain_pin,
		i_divider_select_pin, i_reset_level_select_pin};

	// Strap and trigger pins pass three stages; level taken when two and three agree
	genvar g;
	generate
		for (g = 0; g < 5; g++)
		begin : g_pin
			always_ff @(posedge i_core_clk or negedge i_reset_n)
			begin
				if (!i_reset_n)
				begin
					s1_ff[g]  <= PIN_IDLE[g];
					s2_ff[g]  <= PIN_IDLE[g];
					s3_ff[g]  <= PIN_IDLE[g];
					pin_ff[g] <= PIN_IDLE[g];
				end
				else
				begin
					s1_ff[g] <= pin_raw[g];
					s2_ff[g] <= s1_ff[g];
					s3_ff[g] <= s2_ff[g];
					if (s2_ff[g] == s3_ff[g])
						pin_ff[g] <= s3_ff[g];
				end
			end
		end
	endgenerate

	// Frame decode; frames with nonzero reserved bits or before link ready are dropped
	assign f_addr    = frm_word[`QD_ADDR_MSB:`QD_ADDR_LSB];
	assign f_data    = frm_word[`QD_DATA_MSB:0];
	assign acc       = frm_vld && (state_ff == quad_dac_pkg::ST_RUN) && o_link_ready
		&& (frm_word[`QD_RSV_MSB:`QD_RSV_LSB] == 3'h0);
	assign wr        = acc && !frm_word[`QD_RW_BIT];
	assign init_load = (state_ff == quad_dac_pkg::ST_LOAD);
	assign soft_rst  = wr && hit(f_addr, `QD_ADDR_TRIGGER)
		&& (f_data == `QD_SOFT_RESET_CODE);
	// Load bit acts only on the write itself, so it never stays set
	assign load_trig = (wr && hit(f_addr, `QD_ADDR_TRIGGER) && !soft_rst
		&& f_data[`QD_TRIG_LOAD_BIT]) || (load_prev_ff && !pin_ff[3]);
	assign wr_bcast  = wr && hit(f_addr, `QD_ADDR_BCAST);
	// Halving is the only safe choice when headroom is short
	assign alarm_cond = pin_ff[4] && !o_ref_div2;

	// Load pin edge detect on the filtered level
	always_ff @(posedge i_core_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			load_prev_ff <= 1'b1;
		else
			load_prev_ff <= pin_ff[3];
	end

	// Reset sequencer; straps are captured only after the synchronisers settle
	always_ff @(posedge i_core_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			state_ff  <= quad_dac_pkg::ST_SETTLE;
			settle_ff <= 2'h0;
		end
		else
		begin
			case (state_ff)
				quad_dac_pkg::ST_SETTLE:
				begin
					settle_ff <= settle_ff + 2'h1;
					if (settle_ff == `QD_SETTLE_CYC)
						state_ff <= quad_dac_pkg::ST_LOAD;
				end
				quad_dac_pkg::ST_LOAD:
					state_ff <= quad_dac_pkg::ST_RUN;
				default:
				begin
					settle_ff <= 2'h0;
					if (soft_rst)
						state_ff <= quad_dac_pkg::ST_SETTLE;
				end
			endcase
		end
	end

	// Power-on wait before frames are accepted; restarts on soft reset
	always_ff @(posedge i_core_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			por_cnt_ff   <= 16'h0;
			o_link_ready <= 1'b0;
		end
		else if (state_ff != quad_dac_pkg::ST_RUN)
		begin
			por_cnt_ff   <= 16'h0;
			o_link_ready <= 1'b0;
		end
		else if (por_cnt_ff != 16'(POR_WAIT_CYC))
			por_cnt_ff <= por_cnt_ff + 16'h1;
		else
			o_link_ready <= 1'b1;
	end

	// Per-channel buffer and active code registers
	generate
		for (g = 0; g < 4; g++)
		begin : g_ch
			logic wr_code;
			assign wr_code = wr && (f_addr[3:2] == `QD_CODE_PAGE) && (f_addr[1:0] == 2'(g));

			always_ff @(posedge i_core_clk or negedge i_reset_n)
			begin
				if (!i_reset_n)
				begin
					buf_ff[g]        <= `QD_CODE_ZERO;
					o_active_code[g] <= `QD_CODE_ZERO;
				end
				else if (init_load)
				begin
					// Straight binary, so midscale is just the top bit
					buf_ff[g]        <= pin_ff[0] ? `QD_CODE_MID : `QD_CODE_ZERO;
					o_active_code[g] <= pin_ff[0] ? `QD_CODE_MID : `QD_CODE_ZERO;
				end
				else if (wr_bcast && bcast_en_ff[g])
				begin
					buf_ff[g]        <= f_data;
					o_active_code[g] <= f_data;
				end
				else if (wr_code)
				begin
					buf_ff[g] <= f_data;
					if (!sync_en_ff[g])
						o_active_code[g] <= f_data;
				end
				else if (load_trig && sync_en_ff[g])
					o_active_code[g] <= buf_ff[g];
				// Otherwise the power-up level holds until addressed
			end
		end
	endgenerate

	// Sync register: update mode and broadcast participation
	always_ff @(posedge i_core_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			sync_en_ff  <= `QD_SYNC_EN_RST;
			bcast_en_ff <= `QD_BCAST_EN_RST;
		end
		else if (init_load)
		begin
			sync_en_ff  <= `QD_SYNC_EN_RST;
			bcast_en_ff <= `QD_BCAST_EN_RST;
		end
		else if (wr && hit(f_addr, `QD_ADDR_SYNC))
		begin
			sync_en_ff  <= f_data[`QD_SYNC_EN_LSB +: 4];
			bcast_en_ff <= f_data[`QD_BCAST_EN_LSB +: 4];
		end
	end

	// Config register: reference enable and alarm pin routing
	always_ff @(posedge i_core_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			ref_off_ff <= 1'b0;
			alarm_enable_bit_ff  <= 1'b0;
			alarm_select_bit_ff <= 1'b0;
		end
		else if (init_load)
		begin
			ref_off_ff <= 1'b0;
			alarm_enable_bit_ff  <= 1'b0;
			alarm_select_bit_ff <= 1'b0;
		end
		else if (wr && hit(f_addr, `QD_ADDR_CONFIG))
		begin
			ref_off_ff <= f_data[`QD_CFG_REF_OFF_BIT];
			alarm_enable_bit_ff  <= f_data[`QD_CFG_ALARM_ENABLE_BIT_BIT];
			alarm_select_bit_ff <= f_data[`QD_CFG_ALARM_SELECT_BIT_BIT];
		end
	end

	always_ff @(posedge i_core_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			o_int_ref_en <= 1'b0;
		else
			o_int_ref_en <= (state_ff == quad_dac_pkg::ST_RUN) && !ref_off_ff;
	end

	// Gain register: divider and per-channel gain, seeded from straps
	always_ff @(posedge i_core_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			o_ref_div2 <= 1'b0;
			o_gain_x2  <= 4'h0;
		end
		else if (init_load)
		begin
			o_ref_div2 <= pin_ff[1];
			o_gain_x2  <= {4{pin_ff[2]}};
		end
		else if (wr && hit(f_addr, `QD_ADDR_GAIN))
		begin
			o_ref_div2 <= f_data[`QD_GAIN_DIV_BIT];
			o_gain_x2  <= f_data[`QD_GAIN_CH_LSB +: 4];
		end
	end

	// Alarm: codes untouched, so outputs come back once the divider is fixed
	always_ff @(posedge i_core_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			o_reference_alarm_flag <= 1'b0;
			o_outputs_zero         <= 1'b1;
			o_ref_buf_en           <= 1'b0;
		end
		else
		begin
			o_reference_alarm_flag <= alarm_cond;
			o_outputs_zero         <= alarm_cond;
			o_ref_buf_en           <= !alarm_cond;
		end
	end

	// Readback mux; address decode as a priority chain
	function automatic quad_dac_pkg::code_t rd_data(input logic [3:0] addr);
		rd_data = 16'h0000;
		if (addr[3:2] == `QD_CODE_PAGE)
			rd_data = buf_ff[addr[1:0]];
		else if (hit(addr, `QD_ADDR_ID))
			rd_data = ID_CODE;
		else if (hit(addr, `QD_ADDR_SYNC))
			rd_data = 16'({bcast_en_ff, 4'h0, sync_en_ff});
		else if (hit(addr, `QD_ADDR_CONFIG))
			rd_data = 16'({alarm_select_bit_ff, alarm_enable_bit_ff, 3'h0, ref_off_ff, 8'h00});
		else if (hit(addr, `QD_ADDR_GAIN))
			rd_data = 16'({o_ref_div2, 4'h0, o_gain_x2});
		else if (hit(addr, `QD_ADDR_STATUS))
			rd_data = 16'(o_reference_alarm_flag);
	endfunction

	// Response for the next frame: echo of header plus requested data
	always_ff @(posedge i_core_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			resp_ff <= '0;
		else if (acc)
			resp_ff <= {frm_word[`QD_RW_BIT], 3'h0, f_addr,
				frm_word[`QD_RW_BIT] ? rd_data(f_addr) : 16'h0000};
	end

	// Shared output pin: alarm mode overrides serial data
	always_ff @(posedge i_core_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			o_shared_serial_output_pin    <= 1'b0;
			o_shared_serial_output_pin_oe <= 1'b0;
		end
		else if (alarm_enable_bit_ff && alarm_select_bit_ff)
		begin
			o_shared_serial_output_pin    <= o_reference_alarm_flag;
			o_shared_serial_output_pin_oe <= 1'b1;
		end
		else
		begin
			o_shared_serial_output_pin    <= sdo_bit;
			o_shared_serial_output_pin_oe <= cs_active;
		end
	end

	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_reset_n);

	property p_default;
		init_load |=> o_active_code[0] == ($past(pin_ff[0]) ? `QD_CODE_MID : `QD_CODE_ZERO);
	endproperty
	a_default: assert property (p_default) else $error("default code wrong");

	property p_strap_div;
		init_load |=> o_ref_div2 == $past(pin_ff[1]) && o_gain_x2 == {4{$past(pin_ff[2])}};
	endproperty
	a_strap_div: assert property (p_strap_div) else $error("strap capture wrong");

	property p_async;
		wr && f_addr == 4'h8 && !sync_en_ff[0] && !wr_bcast |=> o_active_code[0] == $past(f_data);
	endproperty
	a_async: assert property (p_async) else $error("async update missed");

	property p_sync_hold;
		wr && f_addr == 4'h8 && sync_en_ff[0] && !load_trig |=> $stable(o_active_code[0]);
	endproperty
	a_sync_hold: assert property (p_sync_hold) else $error("sync channel moved");

	property p_load;
		load_trig && sync_en_ff[0] && !wr_bcast && !(wr && f_addr == 4'h8)
			|=> o_active_code[0] == $past(buf_ff[0]);
	endproperty
	a_load: assert property (p_load) else $error("load transfer missed");

	property p_bcast;
		wr_bcast && bcast_en_ff[0] |=> o_active_code[0] == $past(f_data) && buf_ff[0] == $past(f_data);
	endproperty
	a_bcast: assert property (p_bcast) else $error("broadcast missed");

	property p_alarm;
		alarm_cond |=> o_reference_alarm_flag && o_outputs_zero && !o_ref_buf_en;
	endproperty
	a_alarm: assert property (p_alarm) else $error("alarm not raised");

	property p_alarm_pin;
		alarm_enable_bit_ff && alarm_select_bit_ff |=> o_shared_serial_output_pin_oe
			&& o_shared_serial_output_pin == $past(o_reference_alarm_flag);
	endproperty
	a_alarm_pin: assert property (p_alarm_pin) else $error("alarm pin not routed");

	property p_soft_rst;
		soft_rst |=> state_ff == quad_dac_pkg::ST_SETTLE ##[4:6] init_load;
	endproperty
	a_soft_rst: assert property (p_soft_rst) else $error("soft reset not run");

	property p_readback;
		acc && frm_word[`QD_RW_BIT] && f_addr[3:2] == `QD_CODE_PAGE
			|=> resp_ff[15:0] == $past(buf_ff[f_addr[1:0]]);
	endproperty
	a_readback: assert property (p_readback) else $error("readback not buffer");

	c_async: cover property (wr && f_addr == 4'h8 && !sync_en_ff[0]);
	c_load: cover property (load_trig && sync_en_ff != 4'h0);
	c_bcast: cover property (wr_bcast && bcast_en_ff != 4'h0);
	c_alarm: cover property (alarm_cond ##1 !alarm_cond);
endmodule

// ---- bench/host_spi_model.sv ----
module host_spi_model (
	// Core clock that paces the serial pins
	input  wire logic i_core_clk,
	// Serial pins seen from the host
	output logic      o_sclk,
	output logic      o_cs_n,
	output logic      o_sdi,
	input  wire logic i_sdo
);
	timeunit 1ns;
	timeprecision 1ps;

	// Idle link: clock parked low, select high
	initial
	begin
		o_sclk = 1'b0;
		o_cs_n = 1'b1;
		o_sdi = 1'b0;
	end

	// Phases of 8 core clocks, double what the pin filter needs
	task automatic xfer(input quad_dac_pkg::frame_t w, output quad_dac_pkg::frame_t r);
		int i;
		@(posedge i_core_clk);
		o_cs_n <= 1'b0;
		for (i = 23; i >= 0; i--)
		begin
			repeat (8) @(posedge i_core_clk);
			r[i] = i_sdo;
			o_sdi <= w[i]; // MSB first, 24 bits
			o_sclk <= 1'b1;
			repeat (8) @(posedge i_core_clk);
			o_sclk <= 1'b0;
		end
		repeat (8) @(posedge i_core_clk);
		o_cs_n <= 1'b1;
		o_sdi <= ~w[0]; // Released line shows no stale value
		repeat (24) @(posedge i_core_clk); // Frame length keeps updates over 1 us apart
	endtask
endmodule

// ---- bench/quad_dac_update_control_tb.sv ----
module quad_dac_update_control_tb;
	timeunit 1ns;
	timeprecision 1ps;

	logic                 i_core_clk = 1'b0;
	logic                 i_reset_n = 1'b0;
	logic                 rst_lvl, div_pin, gain_pin;
	logic                 load_n = 1'b1;
	logic                 headroom = 1'b0;
	logic                 sclk, cs_n, sdi, sdo, sdo_oe;
	quad_dac_pkg::code_t  act [4];
	logic [3:0]           gain_o;
	logic                 div_o, iref_o, buf_o, zero_o, alm_o, rdy_o;
	quad_dac_pkg::frame_t rx;
	logic [31:0]          seed = 32'h6847873d;
	int                   n_errors = 0;
	int                   tests_run = 0;
	// Behavioural model of the register state
	int                   m_buf [4];
	int                   m_act [4];
	int                   m_sync, m_bc, m_gain, m_div;

	// 125 MHz core clock
	always #4 i_core_clk = ~i_core_clk;

	quad_dac_update_control #(.POR_WAIT_CYC(20)) quad_dac_update_control_i (
		.i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .i_sclk(sclk), .i_cs_n(cs_n),
		.i_sdi(sdi), .o_shared_serial_output_pin(sdo), .o_shared_serial_output_pin_oe(sdo_oe),
		.i_reset_level_select_pin(rst_lvl), .i_divider_select_pin(div_pin),
		.i_gain_pin(gain_pin), .i_load_trigger_n(load_n), .i_ref_headroom_low(headroom),
		.o_active_code(act), .o_gain_x2(gain_o), .o_ref_div2(div_o), .o_int_ref_en(iref_o),
		.o_ref_buf_en(buf_o), .o_outputs_zero(zero_o), .o_reference_alarm_flag(alm_o),
		.o_link_ready(rdy_o)
	);

	host_spi_model host_spi_model_i (
		.i_core_clk(i_core_clk), .o_sclk(sclk), .o_cs_n(cs_n), .o_sdi(sdi), .i_sdo(sdo)
	);

	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h0);
	endfunction

	task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
		tests_run++;
		if (g !== e)
		begin
			$display("BAD %s expected %h seen %h", n, e, g);
			n_errors++;
		end
	endtask

	task automatic model_reset;
		for (int c = 0; c < 4; c++)
		begin
			m_buf[c] = rst_lvl ? 32'h8000 : 32'h0;
			m_act[c] = m_buf[c];
		end
		m_sync = 0;
		m_bc = 4'hf;
		m_gain = gain_pin ? 4'hf : 4'h0;
		m_div = div_pin;
	endtask

	task automatic check_all;
		for (int c = 0; c < 4; c++)
			chk("active code", 24'(m_act[c]), {8'h0, act[c]});
		chk("gain", 24'(m_gain), {20'h0, gain_o});
		chk("divider", 24'(m_div), {23'h0, div_o});
	endtask

	task automatic wait_ready;
		for (int k = 0; k < 400 && rdy_o !== 1'b1; k++)
			@(posedge i_core_clk);
		chk("link ready", 24'h1, {23'h0, rdy_o});
	endtask

	task automatic load_all;
		for (int c = 0; c < 4; c++)
			if (m_sync[c])
				m_act[c] = m_buf[c];
	endtask

	// Write a register, mirror it in the model, compare active codes, gain and divider
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		host_spi_model_i.xfer({1'b0, 3'b000, a, d}, rx);
		case (a)
			4'h2:
			begin
				m_sync = d[3:0];
				m_bc = d[11:8];
			end
			4'h4:
			begin
				m_gain = d[3:0];
				m_div = d[8];
			end
			4'h5: if (d == 16'h1010) model_reset(); else if (d[4]) load_all();
			4'h6:
				for (int c = 0; c < 4; c++)
					if (m_bc[c])
					begin
						m_buf[c] = d;
						m_act[c] = d;
					end
			4'h8, 4'h9, 4'ha, 4'hb:
			begin
				m_buf[a[1:0]] = d;
				if (!m_sync[a[1:0]])
					m_act[a[1:0]] = d;
			end
			default: ;
		endcase
		check_all();
	endtask

	// Read needs a second frame to bring the answer out
	task automatic rd(input logic [3:0] a, input logic [15:0] e);
		host_spi_model_i.xfer({1'b1, 3'b000, a, 16'h0}, rx);
		host_spi_model_i.xfer(24'h0, rx);
		chk("read frame", {1'b1, 3'b000, a, e}, rx);
	endtask

	task automatic results;
		$display("Checks %0d, mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// Main sequence
	initial
	begin
		seed = lfsr(seed);
		rst_lvl = seed[0];
		div_pin = seed[1];
		gain_pin = seed[2];
		repeat (20) @(posedge i_core_clk);
		i_reset_n <= 1'b1;
		wait_ready();
		model_reset();
		check_all();
		chk("internal ref", 24'h1, {23'h0, iref_o});
		for (int c = 0; c < 4; c++)
		begin
			seed = lfsr(seed);
			wr(4'h8 + 4'(c), seed[15:0]);
		end
		rd(4'ha, 16'(m_buf[2]));
		wr(4'h2, 16'h0503);
		wr(4'h8, 16'hffff);
		wr(4'h9, 16'h0001);
		rd(4'h8, 16'hffff);
		wr(4'h5, 16'h0010);
		rd(4'h5, 16'h0000);
		wr(4'h8, 16'h1234);
		@(posedge i_core_clk);
		load_n <= 1'b0;
		repeat (8) @(posedge i_core_clk);
		load_n <= 1'b1;
		repeat (12) @(posedge i_core_clk);
		load_all();
		check_all();
		wr(4'h6, 16'h5a5a);
		wr(4'h4, 16'h0105);
		wr(4'h4, 16'h000a);
		headroom <= 1'b1;
		repeat (12) @(posedge i_core_clk);
		chk("alarm flag", 24'h1, {23'h0, alm_o});
		chk("outputs zero", 24'h1, {23'h0, zero_o});
		chk("ref buffer", 24'h0, {23'h0, buf_o});
		check_all();
		rd(4'h7, 16'h0001);
		wr(4'h3, 16'h3000);
		chk("alarm pin drive", 24'h1, {23'h0, sdo_oe});
		chk("alarm pin level", 24'h1, {23'h0, sdo});
		wr(4'h4, 16'h010a);
		chk("alarm cleared", 24'h0, {23'h0, alm_o});
		chk("outputs back", 24'h0, {23'h0, zero_o});
		headroom <= 1'b0;
		wr(4'h3, 16'h0100);
		chk("internal ref off", 24'h0, {23'h0, iref_o});
		rd(4'h3, 16'h0100);
		rd(4'h4, 16'h010a);
		host_spi_model_i.xfer({1'b0, 3'b010, 4'h8, 16'hbeef}, rx);
		check_all();
		wr(4'h5, 16'h1010);
		wait_ready();
		check_all();
		rd(4'h2, 16'h0f00);
		chk("internal ref back", 24'h1, {23'h0, iref_o});
		results();
	end

	// Watchdog sized well above the roughly 13000 cycles of traffic
	initial
	begin
		#(8 * 80000);
		n_errors++;
		results();
	end
endmodule
